// ==== mac_rx_filter_tx_status.sv ====
`timescale 1ns/100ps
// Summary of operation
// - transmit status clears when software starts the next transmission
// - a status bit sets only when its media event occurs during sending
// - transmit status content is unspecified until the first transmission ends
// - crc or alignment errored packets dropped unless keep errored set
// - with hashed group acceptance, group packets other than all-ones kept only on hash hit
// - physical packets must match station address unless any physical set
module mac_rx_filter_tx_status (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [7:0]  tx_event_i,
    input  wire logic        tx_done_i,
    output logic             tx_busy_o,
    input  wire logic        rx_end_i,
    input  wire logic [47:0] rx_dest_i,
    input  wire logic [15:0] rx_len_i,
    input  wire logic        rx_crc_err_i,
    input  wire logic        rx_align_err_i,
    input  wire logic        rx_hash_hit_i,
    output logic             rx_keep_o,
    output logic             rx_drop_o,
    output logic             irq_o
);
    import mrf_pkg::*;

    // ----------------------------------------------------------------
    // media event synchroniser
    // ----------------------------------------------------------------
    logic [7:0] ev_meta_q;
    logic [7:0] ev_sync_q;
    logic       done_meta_q;
    logic       done_sync_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ev_meta_q   <= 8'h00;
            ev_sync_q   <= 8'h00;
            done_meta_q <= 1'b0;
            done_sync_q <= 1'b0;
        end else begin
            ev_meta_q   <= tx_event_i;
            ev_sync_q   <= ev_meta_q;
            done_meta_q <= tx_done_i;
            done_sync_q <= done_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // bus address phase and decode
    // ----------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;

    wire       addr_take = hsel_i && hready_i && htrans_i[1];
    wire       in_map    = (haddr_i[31:8] == 24'h00_0000);
    wire [7:0] a_lo      = haddr_i[7:0];

    wire wr_ctrl   = wr_pend_q && (wr_addr_q == MRF_OFF_CTRL);
    wire wr_cfg    = wr_pend_q && (wr_addr_q == MRF_OFF_RX_CFG);
    wire wr_sa_lo  = wr_pend_q && (wr_addr_q == MRF_OFF_SA_LO);
    wire wr_sa_hi  = wr_pend_q && (wr_addr_q == MRF_OFF_SA_HI);
    wire wr_istat  = wr_pend_q && (wr_addr_q == MRF_OFF_IRQ_STAT);
    wire wr_imask  = wr_pend_q && (wr_addr_q == MRF_OFF_IRQ_MASK);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite_i && in_map;
            wr_addr_q <= a_lo;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    logic [4:0]  cfg_q;
    logic [47:0] sa_q;
    logic [2:0]  imask_q;
    logic [2:0]  istat_q;
    logic [2:0]  istat_d;
    logic        start_q;
    logic [7:0]  tx_status;
    logic        tx_busy;
    logic        tx_done_ev;
    logic        rx_keep;
    logic        rx_drop;

    wire start_now = wr_ctrl && hwdata_i[MRF_CTRL_START] && !start_q;
    wire [2:0] ev_set = {rx_drop, rx_keep, tx_done_ev};
    wire [2:0] ev_clr = wr_istat ? hwdata_i[MRF_IRQ_WIDTH-1:0] : 3'h0;

    // events win over a write-one clear in the same cycle
    assign istat_d = (istat_q & ~ev_clr) | ev_set;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_q   <= MRF_CFG_RST;
            sa_q    <= MRF_SA_RST;
            imask_q <= MRF_IRQ_RST;
            istat_q <= MRF_IRQ_RST;
            start_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= hwdata_i[MRF_CFG_WIDTH-1:0];
            end
            if (wr_sa_lo) begin
                sa_q[31:0] <= hwdata_i;
            end
            if (wr_sa_hi) begin
                sa_q[47:32] <= hwdata_i[15:0];
            end
            if (wr_imask) begin
                imask_q <= hwdata_i[MRF_IRQ_WIDTH-1:0];
            end
            istat_q <= istat_d;
            start_q <= start_now;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [31:0] rd_ctrl  = {30'h0000_0000, tx_busy, 1'b0};
    wire [31:0] rd_stat  = {24'h00_0000, tx_status};
    wire [31:0] rd_cfg   = {27'h000_0000, cfg_q};
    wire [31:0] rd_sa_hi = {16'h0000, sa_q[47:32]};
    wire [31:0] rd_istat = {29'h0000_0000, istat_q};
    wire [31:0] rd_imask = {29'h0000_0000, imask_q};
    wire [31:0] rd_word  =
        !in_map                       ? MRF_WORD_ZERO :
        (a_lo == MRF_OFF_CTRL)        ? rd_ctrl :
        (a_lo == MRF_OFF_TX_STAT)     ? rd_stat :
        (a_lo == MRF_OFF_RX_CFG)      ? rd_cfg :
        (a_lo == MRF_OFF_SA_LO)       ? sa_q[31:0] :
        (a_lo == MRF_OFF_SA_HI)       ? rd_sa_hi :
        (a_lo == MRF_OFF_IRQ_STAT)    ? rd_istat :
        (a_lo == MRF_OFF_IRQ_MASK)    ? rd_imask : MRF_WORD_ZERO;
    wire rd_take = addr_take && !hwrite_i;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_q     <= MRF_WORD_ZERO;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
            irq_o       <= 1'b0;
        end else begin
            rdata_q     <= rd_take ? rd_word : MRF_WORD_ZERO;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            irq_o       <= |(istat_d & imask_q);
        end
    end

    assign hrdata_o = rdata_q;

    // ----------------------------------------------------------------
    // transmit status and receive filter
    // ----------------------------------------------------------------
    mrf_cfg_if cfg_bus ();

    assign cfg_bus.keep_errored_packets        = cfg_q[MRF_CFG_KEEP_ERR];
    assign cfg_bus.accept_short_packets        = cfg_q[MRF_CFG_SHORT];
    assign cfg_bus.accept_all_ones_destination = cfg_q[MRF_CFG_ONES];
    assign cfg_bus.accept_hashed_group_address = cfg_q[MRF_CFG_HASHED];
    assign cfg_bus.accept_any_physical_address = cfg_q[MRF_CFG_ANY_PHYS];
    assign cfg_bus.station_address_bytes       = sa_q;

    mrf_tx_status u_tx (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .start_i  (start_q),
        .done_i   (done_sync_q),
        .event_i  (ev_sync_q),
        .status_o (tx_status),
        .busy_o   (tx_busy),
        .done_o   (tx_done_ev)
    );

    mrf_rx_accept u_rx (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .cfg         (cfg_bus),
        .end_i       (rx_end_i),
        .dest_i      (rx_dest_i),
        .len_i       (rx_len_i),
        .crc_err_i   (rx_crc_err_i),
        .align_err_i (rx_align_err_i),
        .hash_hit_i  (rx_hash_hit_i),
        .keep_o      (rx_keep),
        .drop_o      (rx_drop)
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_busy_o <= 1'b0;
            rx_keep_o <= 1'b0;
            rx_drop_o <= 1'b0;
        end else begin
            tx_busy_o <= tx_busy;
            rx_keep_o <= rx_keep;
            rx_drop_o <= rx_drop;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    start_clear_a: assert property (start_q && ev_sync_q == 8'h00 |=> tx_status == 8'h00)
        else $error("start did not clear transmit status");
    event_seen_a: assert property (tx_busy && !start_q && ev_sync_q[0] |=> tx_status[0])
        else $error("media event not recorded");
    cfg_steer_a: assert property (wr_cfg |=> cfg_q == $past(hwdata_i[4:0]))
        else $error("receive configuration not stored");
    unmapped_zero_a: assert property (rd_take && !in_map |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    set_wins_a: assert property (wr_istat && hwdata_i[0] && tx_done_ev |=> istat_q[0])
        else $error("event lost to clear");
    irq_level_a: assert property (irq_o == |(istat_q & $past(imask_q)))
        else $error("interrupt level wrong");
    irq_raise_c: cover property (tx_done_ev ##[1:3] irq_o);
    read_stat_c: cover property (rd_take && a_lo == MRF_OFF_TX_STAT);
endmodule // mac_rx_filter_tx_status

// ==== mrf_pkg.sv ====
package mrf_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  MRF_OFF_CTRL     = 8'h00;
    localparam logic [7:0]  MRF_OFF_TX_STAT  = 8'h04;
    localparam logic [7:0]  MRF_OFF_RX_CFG   = 8'h08;
    localparam logic [7:0]  MRF_OFF_SA_LO    = 8'h0C;
    localparam logic [7:0]  MRF_OFF_SA_HI    = 8'h10;
    localparam logic [7:0]  MRF_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0]  MRF_OFF_IRQ_MASK = 8'h18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          MRF_CTRL_START   = 0;
    localparam int          MRF_CTRL_BUSY    = 1;
    localparam int          MRF_CFG_KEEP_ERR = 0;
    localparam int          MRF_CFG_SHORT    = 1;
    localparam int          MRF_CFG_ONES     = 2;
    localparam int          MRF_CFG_HASHED   = 3;
    localparam int          MRF_CFG_ANY_PHYS = 4;
    localparam int          MRF_CFG_WIDTH    = 5;
    localparam int          MRF_IRQ_TX_DONE  = 0;
    localparam int          MRF_IRQ_RX_KEEP  = 1;
    localparam int          MRF_IRQ_RX_DROP  = 2;
    localparam int          MRF_IRQ_WIDTH    = 3;
    localparam int          MRF_GROUP_BIT    = 40;

    // ----------------------------------------------------------------
    // reset values and limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  MRF_TX_STAT_RST  = 8'h00;
    localparam logic [4:0]  MRF_CFG_RST      = 5'h00;
    localparam logic [47:0] MRF_SA_RST       = 48'h0000_0000_0000;
    localparam logic [2:0]  MRF_IRQ_RST      = 3'h0;
    localparam logic [31:0] MRF_WORD_ZERO    = 32'h0000_0000;
    localparam logic [15:0] MRF_MIN_LEN      = 16'h0040;
    localparam logic [15:0] MRF_RUNT_MIN_LEN = 16'h0008;

    // ----------------------------------------------------------------
    // transmit tracking states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MRF_TX_IDLE = 2'b01,
        MRF_TX_BUSY = 2'b10
    } mrf_tx_state_e;

endpackage

// ==== mrf_cfg_if.sv ====
`timescale 1ns/100ps
interface mrf_cfg_if;
    logic        keep_errored_packets;
    logic        accept_short_packets;
    logic        accept_all_ones_destination;
    logic        accept_hashed_group_address;
    logic        accept_any_physical_address;
    logic [47:0] station_address_bytes;

    modport cfg (
        output keep_errored_packets, accept_short_packets, accept_all_ones_destination,
               accept_hashed_group_address, accept_any_physical_address, station_address_bytes
    );
    modport filt (
        input  keep_errored_packets, accept_short_packets, accept_all_ones_destination,
               accept_hashed_group_address, accept_any_physical_address, station_address_bytes
    );
endinterface

// ==== mrf_tx_status.sv ====
`timescale 1ns/100ps
module mrf_tx_status (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       done_i,
    input  wire logic [7:0] event_i,
    output logic [7:0]      status_o,
    output logic            busy_o,
    output logic            done_o
);
    import mrf_pkg::*;

    mrf_tx_state_e state_q;
    mrf_tx_state_e state_d;
    logic [7:0]    status_d;
    wire           in_tx = (state_q == MRF_TX_BUSY);

    always_comb begin
        case (state_q)
            MRF_TX_IDLE: state_d = start_i ? MRF_TX_BUSY : MRF_TX_IDLE;
            MRF_TX_BUSY: state_d = (done_i && !start_i) ? MRF_TX_IDLE : MRF_TX_BUSY;
            default:     state_d = MRF_TX_IDLE;
        endcase
    end

    // clear on start, then gather events of this packet only
    assign status_d = start_i ? event_i : (in_tx ? (status_o | event_i) : status_o);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q  <= MRF_TX_IDLE;
            status_o <= MRF_TX_STAT_RST;
            done_o   <= 1'b0;
        end else begin
            state_q  <= state_d;
            status_o <= status_d;
            done_o   <= in_tx && done_i && !start_i;
        end
    end

    assign busy_o = in_tx;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    start_clears_a: assert property (start_i && event_i == 8'h00 |=> status_o == 8'h00)
        else $error("status not cleared by start");
    no_spurious_a: assert property (!start_i && (!in_tx || event_i == 8'h00) |=> $stable(status_o))
        else $error("status changed without event");
    tx_cycle_c: cover property (start_i ##[1:50] done_o);
endmodule // mrf_tx_status

// ==== mrf_rx_accept.sv ====
`timescale 1ns/100ps
module mrf_rx_accept (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    mrf_cfg_if.filt          cfg,
    input  wire logic        end_i,
    input  wire logic [47:0] dest_i,
    input  wire logic [15:0] len_i,
    input  wire logic        crc_err_i,
    input  wire logic        align_err_i,
    input  wire logic        hash_hit_i,
    output logic             keep_o,
    output logic             drop_o
);
    import mrf_pkg::*;

    wire is_ones  = &dest_i;
    wire is_group = dest_i[MRF_GROUP_BIT];
    wire grp_ok   = cfg.accept_hashed_group_address && hash_hit_i;
    wire phys_ok  = cfg.accept_any_physical_address || (dest_i == cfg.station_address_bytes);
    wire addr_ok  = is_ones ? cfg.accept_all_ones_destination : (is_group ? grp_ok : phys_ok);
    wire len_ok   = (len_i >= MRF_MIN_LEN) || (cfg.accept_short_packets && len_i >= MRF_RUNT_MIN_LEN);
    wire err_ok   = !(crc_err_i || align_err_i) || cfg.keep_errored_packets;
    wire keep_now = addr_ok && len_ok && err_ok;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            keep_o <= 1'b0;
            drop_o <= 1'b0;
        end else begin
            keep_o <= end_i && keep_now;
            drop_o <= end_i && !keep_now;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    err_drop_a: assert property (end_i && crc_err_i && !cfg.keep_errored_packets |=> drop_o)
        else $error("errored packet kept");
    hash_need_a: assert property (end_i && is_group && !is_ones && !hash_hit_i |=> !keep_o)
        else $error("group packet kept without hash hit");
    phys_match_a: assert property (end_i && !is_group && !cfg.accept_any_physical_address
        && dest_i != cfg.station_address_bytes |=> drop_o)
        else $error("foreign physical packet kept");
    runt_floor_a: assert property (end_i && len_i < MRF_RUNT_MIN_LEN |=> drop_o && !keep_o)
        else $error("tiny packet kept");
    short_drop_a: assert property (end_i && len_i < MRF_MIN_LEN && !cfg.accept_short_packets |=> drop_o)
        else $error("runt kept while disabled");
    runt_kept_c: cover property (end_i && len_i < MRF_MIN_LEN ##1 keep_o);
    group_kept_c: cover property (end_i && is_group && !is_ones ##1 keep_o);
endmodule // mrf_rx_accept

// ==== mrf_medium_model.sv ====
`timescale 1ns/100ps
module mrf_medium_model (
    input  wire logic  clock_i,
    output logic [7:0] tx_event_o,
    output logic       tx_done_o,
    output logic       rx_end_o,
    output logic [47:0] rx_dest_o,
    output logic [15:0] rx_len_o,
    output logic       rx_crc_err_o,
    output logic       rx_align_err_o,
    output logic       rx_hash_hit_o
);
    initial begin
        tx_event_o     = 8'h00;
        tx_done_o      = 1'b0;
        rx_end_o       = 1'b0;
        rx_dest_o      = 48'h0000_0000_0000;
        rx_len_o       = 16'h0000;
        rx_crc_err_o   = 1'b0;
        rx_align_err_o = 1'b0;
        rx_hash_hit_o  = 1'b0;
    end

    // ----------------------------------------------------------------
    // media events during sending, held long enough for the sync
    // ----------------------------------------------------------------
    task automatic media_event(input logic [7:0] ev);
        @(posedge clock_i);
        tx_event_o <= ev;
        repeat (2) @(posedge clock_i);
        tx_event_o <= 8'h00;
    endtask

    task automatic end_tx();
        @(posedge clock_i);
        tx_done_o <= 1'b1;
        repeat (2) @(posedge clock_i);
        tx_done_o <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // one received frame; descriptor lines scrambled once released
    // ----------------------------------------------------------------
    task automatic frame(input logic [47:0] d, input logic [15:0] l, input logic c, input logic a,
                         input logic h);
        @(posedge clock_i);
        rx_end_o       <= 1'b1;
        rx_dest_o      <= d;
        rx_len_o       <= l;
        rx_crc_err_o   <= c;
        rx_align_err_o <= a;
        rx_hash_hit_o  <= h;
        @(posedge clock_i);
        rx_end_o       <= 1'b0;
        rx_dest_o      <= ~d;
        rx_len_o       <= ~l;
        rx_crc_err_o   <= ~c;
        rx_align_err_o <= ~a;
        rx_hash_hit_o  <= ~h;
    endtask
endmodule // mrf_medium_model

// ==== mac_rx_filter_tx_status_tb.sv ====
`timescale 1ns/100ps
module mac_rx_filter_tx_status_tb;
    import mrf_pkg::*;
    logic        clock_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, tmp;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [7:0]  tx_event_i;
    logic        tx_done_i, tx_busy_o, rx_end_i, rx_crc, rx_align, rx_hash, rx_keep_o, rx_drop_o;
    logic [47:0] rx_dest;
    logic [15:0] rx_len;
    int          miscompares = 0;
    int          total_checks = 0;
    localparam logic [47:0] STN = 48'h1022_3344_5566;
    localparam logic [47:0] OTH = 48'h0200_0000_0001;
    localparam logic [47:0] GRP = 48'h0100_5e00_0001;
    localparam logic [47:0] BC  = 48'hffff_ffff_ffff;

    mac_rx_filter_tx_status u_dut (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .tx_event_i(tx_event_i), .tx_done_i(tx_done_i), .tx_busy_o(tx_busy_o), .rx_end_i(rx_end_i),
        .rx_dest_i(rx_dest), .rx_len_i(rx_len), .rx_crc_err_i(rx_crc), .rx_align_err_i(rx_align),
        .rx_hash_hit_i(rx_hash), .rx_keep_o(rx_keep_o), .rx_drop_o(rx_drop_o), .irq_o(irq_o));

    mrf_medium_model u_med (.clock_i(clock_i), .tx_event_o(tx_event_i), .tx_done_o(tx_done_i),
        .rx_end_o(rx_end_i), .rx_dest_o(rx_dest), .rx_len_o(rx_len), .rx_crc_err_o(rx_crc),
        .rx_align_err_o(rx_align), .rx_hash_hit_o(rx_hash));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // compare, verdict and bus tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        hsel_i   <= 1'b1;
        haddr_i  <= {24'h00_0000, a};
        htrans_i <= 2'b10;
        hwrite_i <= w;
        n = 0;
        do begin @(posedge clock_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
        hsel_i   <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do begin @(posedge clock_i); n++; end while (hreadyout_o !== 1'b1 && n < 40);
        rd = hrdata_o;
        if (n >= 40) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, tmp);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000, tmp);
        check(nm, tmp, exp);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin @(posedge clock_i); #1; n++; end while (tx_busy_o !== 1'b0 && n < 30);
        @(posedge clock_i);
        if (n >= 30) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic rx_case(input logic [4:0] cfg, input logic [47:0] d, input logic [15:0] l,
                           input logic c, input logic a, input logic h, input logic keep);
        int n;
        wr(MRF_OFF_RX_CFG, {27'h000_0000, cfg});
        u_med.frame(d, l, c, a, h);
        n = 0;
        do begin @(posedge clock_i); #1; n++; end while (rx_keep_o !== 1'b1 && rx_drop_o !== 1'b1 && n < 6);
        check("rx keep drop", {30'h0000_0000, rx_keep_o, rx_drop_o}, {30'h0000_0000, keep, ~keep});
        @(posedge clock_i);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_i    = 1'b1;
        hsel_i   = 1'b0;
        haddr_i  = 32'h0000_0000;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i  = 3'b010;
        hwdata_i = 32'h0000_0000;
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd_chk("rx cfg reset", MRF_OFF_RX_CFG, 32'h0000_0000);
        rd_chk("irq mask reset", MRF_OFF_IRQ_MASK, 32'h0000_0000);
        rd_chk("irq stat reset", MRF_OFF_IRQ_STAT, 32'h0000_0000);
        wr(MRF_OFF_RX_CFG, 32'hffff_ffff);
        rd_chk("rx cfg width", MRF_OFF_RX_CFG, 32'h0000_001f);
        wr(8'h40, 32'hffff_ffff);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        wr(MRF_OFF_SA_LO, 32'h3344_5566);
        wr(MRF_OFF_SA_HI, 32'h0000_1022);
        wr(MRF_OFF_IRQ_MASK, 32'h0000_0001);
        // first transmission
        wr(MRF_OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock_i);
        check("busy", {31'h0000_0000, tx_busy_o}, 32'h0000_0001);
        rd_chk("ctrl busy", MRF_OFF_CTRL, 32'h0000_0002);
        u_med.media_event(8'h05);
        repeat (5) @(posedge clock_i);
        u_med.end_tx();
        wait_idle();
        rd_chk("status after", MRF_OFF_TX_STAT, 32'h0000_0005);
        check("irq tx", {31'h0000_0000, irq_o}, 32'h0000_0001);
        wr(MRF_OFF_TX_STAT, 32'h0000_00ff);
        rd_chk("status ro", MRF_OFF_TX_STAT, 32'h0000_0005);
        wr(MRF_OFF_IRQ_STAT, 32'h0000_0001);
        @(posedge clock_i);
        check("irq cleared", {31'h0000_0000, irq_o}, 32'h0000_0000);
        u_med.media_event(8'h40);
        repeat (5) @(posedge clock_i);
        rd_chk("idle event", MRF_OFF_TX_STAT, 32'h0000_0005);
        // second transmission
        wr(MRF_OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock_i);
        rd_chk("status restart", MRF_OFF_TX_STAT, 32'h0000_0000);
        u_med.media_event(8'h82);
        repeat (5) @(posedge clock_i);
        rd_chk("status events", MRF_OFF_TX_STAT, 32'h0000_0082);
        u_med.end_tx();
        wait_idle();
        rd_chk("status second", MRF_OFF_TX_STAT, 32'h0000_0082);
        // receive filtering
        rx_case(5'h00, STN, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(5'h00, OTH, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_case(5'h10, OTH, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(5'h00, STN, 16'h003f, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_case(5'h02, STN, 16'h0008, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(5'h02, STN, 16'h0007, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_case(5'h00, STN, 16'h0040, 1'b1, 1'b0, 1'b0, 1'b0);
        rx_case(5'h00, STN, 16'h0040, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_case(5'h01, STN, 16'h0040, 1'b1, 1'b0, 1'b0, 1'b1);
        rx_case(5'h01, STN, 16'h0040, 1'b1, 1'b1, 1'b0, 1'b1);
        rx_case(5'h08, GRP, 16'h0040, 1'b0, 1'b0, 1'b1, 1'b1);
        rx_case(5'h08, GRP, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_case(5'h00, GRP, 16'h0040, 1'b0, 1'b0, 1'b1, 1'b0);
        rx_case(5'h04, BC, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_case(5'h00, BC, 16'h0040, 1'b0, 1'b0, 1'b0, 1'b0);
        // interrupt status and masking
        rd_chk("irq stat", MRF_OFF_IRQ_STAT, 32'h0000_0007);
        wr(MRF_OFF_IRQ_STAT, 32'h0000_0001);
        @(posedge clock_i);
        check("irq masked", {31'h0000_0000, irq_o}, 32'h0000_0000);
        wr(MRF_OFF_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge clock_i);
        check("irq unmasked", {31'h0000_0000, irq_o}, 32'h0000_0001);
        rd_chk("irq stat left", MRF_OFF_IRQ_STAT, 32'h0000_0006);
        check("hresp okay", {31'h0000_0000, hresp_o}, 32'h0000_0000);
        give_verdict();
    end
endmodule // mac_rx_filter_tx_status_tb
